// ==== verilog/lsd_top.sv ====
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Eight backplanes, 56 frontplanes, 448 segments
// - Multiplexed 1/4, 1/5, 1/8 duty, 1/3 bias
// - Supply enable switches the drive levels on
// - Software sets supply enable even with external supply
// - DC frontplanes act as plain outputs always
// - All-on forces the on waveform on every non-DC frontplane
// - Blank forces off; otherwise memory drives
// - All-on beats blank when both set
// - Duty field selects backplanes in use
// - Frame rates 32, 25, 32 Hz
// - Static mode only with half-bias option
// - Static: any mapped bit gives on
// - Static: all bits zero gives dynamic off
// - Display memory F000H-F09FH, build-time mapping
// - Bit one is segment on, zero off
// - Display memory not reset; software initialises
// - Memory read/write; spare words general storage
module lsd_top
  import lsd_pkg::*;
#(
  parameter logic [27:0] DC_PAIR_MASK  = 28'h0000000,
  parameter logic        HALF_BIAS_OPT = 1'b0
)
(
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              slow_oscillator_clock_i,
  output logic                   bias_enable_o,
  output lsd_drive_t             drive_o
);

  // ==========================================================================
  // Segment map
  // ==========================================================================
  // Build-time allocation: frontplane s, backplane c -> bit s*8+c
  function automatic logic [7:0] seg_addr(input int unsigned s, input logic [2:0] c);
    int unsigned idx;
    idx = s * 8 + int'(c);
    return 8'(idx >> 2);
  endfunction

  function automatic logic [1:0] seg_bit(input logic [2:0] c);
    return c[1:0];
  endfunction

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [3:0]  dmem [DMEM_WORDS];                     // No reset
  logic [5:0]  ctrl_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        osc_sync1_reg;
  logic        osc_sync2_reg;
  logic        osc_last_reg;
  logic [8:0]  tick_cnt_reg;
  logic [2:0]  slot_reg;
  lsd_drive_t  drive_reg;
  lsd_drive_t  drive_next;
  logic        bias_en_reg;

  logic        supply_on;
  logic        all_on;
  logic        blank;
  logic        static_on;
  logic [3:0]  ncom;
  logic [8:0]  slot_ticks;
  logic        phase;
  logic        osc_tick;
  logic [17:0] idx;
  logic        idx_dmem;
  logic        idx_ok;
  logic        access;
  logic [7:0]  dmem_addr;

  assign supply_on = ctrl_reg[CTRL_SUPPLY_BIT];
  assign all_on    = ctrl_reg[CTRL_ALLON_BIT];
  assign blank     = ctrl_reg[CTRL_BLANK_BIT];
  assign static_on = ctrl_reg[CTRL_STATIC_BIT];

  // Duty decode; low bit ignored when high bit set
  always_comb
  begin
    if (ctrl_reg[CTRL_DUTYH_BIT])
    begin
      ncom       = 4'h8;
      slot_ticks = SLOT_TICKS_8;
    end
    else if (ctrl_reg[CTRL_DUTYL_BIT])
    begin
      ncom       = 4'h5;
      slot_ticks = SLOT_TICKS_5;
    end
    else
    begin
      ncom       = 4'h4;
      slot_ticks = SLOT_TICKS_4;
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign idx       = paddr_i[ADDR_W-1:2];
  assign idx_dmem  = (idx >= DMEM_FIRST_IDX) && (idx <= DMEM_LAST_IDX);
  assign dmem_addr = 8'(idx - DMEM_FIRST_IDX);
  assign idx_ok    = (paddr_i[1:0] == 2'h0) && (idx_dmem || idx == CTRL_IDX || idx == STAT_IDX);
  assign access    = psel_i && penable_i && pready_reg;

  // One wait state: pready rises on the second access cycle
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else
    begin
      pready_reg  <= psel_i && penable_i && !pready_reg;
      pslverr_reg <= psel_i && penable_i && !pready_reg && !idx_ok;
      if (psel_i && penable_i && !pready_reg)
      begin
        if (!idx_ok)
          prdata_reg <= 32'h00000000;
        else if (idx_dmem)
          prdata_reg <= {28'h0000000, dmem[dmem_addr]};
        else if (idx == CTRL_IDX)
          prdata_reg <= {26'h0000000, ctrl_reg};
        else
          prdata_reg <= {28'h0000000, phase, slot_reg};
      end
    end
  end

  // Display memory writes; contents stay undefined until software writes
  always_ff @(posedge clk_i)
  begin
    if (access && pwrite_i && idx_ok && idx_dmem)
      dmem[dmem_addr] <= pwdata_i[3:0];
  end

  // Control register; static bit sticks at zero without the half-bias option
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl_reg <= CTRL_RESET;
    else if (access && pwrite_i && idx_ok && idx == CTRL_IDX)
    begin
      ctrl_reg                  <= pwdata_i[5:0];
      ctrl_reg[CTRL_STATIC_BIT] <= pwdata_i[CTRL_STATIC_BIT] && HALF_BIAS_OPT;
    end
  end

  // ==========================================================================
  // Frame timing
  // ==========================================================================
  // Oscillator pin is asynchronous: two flops, then edge detect on the second
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
      osc_last_reg  <= 1'b0;
    end
    else
    begin
      osc_sync1_reg <= slow_oscillator_clock_i;
      osc_sync2_reg <= osc_sync1_reg;
      osc_last_reg  <= osc_sync2_reg;
    end
  end

  assign osc_tick = osc_sync2_reg && !osc_last_reg;
  // Second half of each slot inverts polarity so the glass sees no DC
  assign phase    = tick_cnt_reg >= (slot_ticks >> 1);

  // Slot stepping; a duty change that leaves the slot outside the new duty wraps to slot zero
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tick_cnt_reg <= 9'h000;
      slot_reg     <= 3'h0;
    end
    // Slot left outside a shortened duty: restart the frame at slot zero
    else if ({1'b0, slot_reg} >= ncom)
    begin
      tick_cnt_reg <= 9'h000;
      slot_reg     <= 3'h0;
    end
    else if (tick_cnt_reg >= slot_ticks)
      tick_cnt_reg <= 9'h000;
    else if (osc_tick)
    begin
      if (tick_cnt_reg == slot_ticks - 9'h001)
      begin
        tick_cnt_reg <= 9'h000;
        if ({1'b0, slot_reg} >= ncom - 4'h1)
          slot_reg <= 3'h0;
        else
          slot_reg <= slot_reg + 3'h1;
      end
      else
        tick_cnt_reg <= tick_cnt_reg + 9'h001;
    end
  end

  // ==========================================================================
  // Waveform composition
  // ==========================================================================
  lsd_level_t sel_lvl;
  lsd_level_t nsel_lvl;
  lsd_level_t on_lvl;
  lsd_level_t off_lvl;

  // 1/3 bias: selected swings full, others sit at VC1/VC2
  assign sel_lvl  = phase ? LVL_V0  : LVL_VC3;
  assign nsel_lvl = phase ? LVL_VC2 : LVL_VC1;
  assign on_lvl   = phase ? LVL_VC3 : LVL_V0;
  assign off_lvl  = phase ? LVL_VC1 : LVL_VC2;

  always_comb
  begin
    logic any_set;
    logic [3:0] w;
    any_set    = 1'b0;
    w          = 4'h0;
    drive_next = '0;
    for (int c = 0; c < NUM_BP; c++)
    begin
      if (!supply_on || c >= int'(ncom))
        drive_next.backplane_lines[c] = LVL_V0;
      else if (static_on || c == int'(slot_reg))
        drive_next.backplane_lines[c] = sel_lvl;
      else
        drive_next.backplane_lines[c] = nsel_lvl;
    end
    for (int unsigned s = 0; s < NUM_FP; s++)
    begin
      any_set = 1'b0;
      for (int c = 0; c < NUM_BP; c++)
      begin
        w       = dmem[seg_addr(s, 3'(c))];
        any_set = any_set | w[seg_bit(3'(c))];
      end
      w = dmem[seg_addr(s, slot_reg)];
      if (DC_PAIR_MASK[s >> 1])
        drive_next.frontplane_lines[s] = dmem[seg_addr(s, 3'h0)][0] ? LVL_VC3 : LVL_V0;
      else if (!supply_on)
        drive_next.frontplane_lines[s] = LVL_V0;
      else if (all_on)
        drive_next.frontplane_lines[s] = on_lvl;
      else if (blank)
        drive_next.frontplane_lines[s] = off_lvl;
      else if (static_on)
        drive_next.frontplane_lines[s] = any_set ? on_lvl : off_lvl;
      else
        drive_next.frontplane_lines[s] = w[seg_bit(slot_reg)] ? on_lvl : off_lvl;
    end
  end

  // Registered pins and bias generator enable
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      drive_reg   <= '0;
      bias_en_reg <= 1'b0;
    end
    else
    begin
      drive_reg   <= drive_next;
      bias_en_reg <= supply_on;
    end
  end

  assign drive_o       = drive_reg;
  assign bias_enable_o = bias_en_reg;
  assign prdata_o      = prdata_reg;
  assign pready_o      = pready_reg;
  assign pslverr_o     = pslverr_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_all_on_wins: assert property (supply_on && all_on && blank && !DC_PAIR_MASK[27]
    |=> drive_reg.frontplane_lines[NUM_FP-1] == $past(on_lvl))
    else $error("all-on did not win over blank");

  a_blank_forces_off: assert property (supply_on && !all_on && blank && !DC_PAIR_MASK[27]
    |=> drive_reg.frontplane_lines[NUM_FP-1] == $past(off_lvl))
    else $error("blank did not give off waveform");

  a_supply_off_quiet: assert property (!supply_on
    |=> drive_reg.backplane_lines == '0 && !bias_enable_o)
    else $error("outputs active with supply off");

  a_static_gated: assert property (!HALF_BIAS_OPT |-> !static_on)
    else $error("static mode entered without option");

  a_slot_in_duty: assert property ({1'b0, slot_reg} < ncom || $changed(ncom))
    else $error("backplane slot outside duty");

  a_slot_length: assert property (osc_tick && tick_cnt_reg == slot_ticks - 9'h001
    && $stable(ctrl_reg) |=> tick_cnt_reg == 9'h000)
    else $error("slot did not end at tick count");

  a_bp_selected: assert property (supply_on && !static_on && slot_reg == 3'h0
    |=> drive_reg.backplane_lines[0] == $past(sel_lvl))
    else $error("slot backplane not selected");

  a_unused_bp_low: assert property (!ctrl_reg[CTRL_DUTYH_BIT] |=> drive_reg.backplane_lines[7] == 2'b00)
    else $error("unused backplane driven");

  a_apb_one_wait: assert property (psel_i && penable_i && !pready_reg |=> pready_o ##1 !pready_o)
    else $error("apb answer timing wrong");

  c_duty_eight: cover property (ctrl_reg[CTRL_DUTYH_BIT] && slot_reg == 3'h7);
  c_duty_five:  cover property (!ctrl_reg[CTRL_DUTYH_BIT] && ctrl_reg[CTRL_DUTYL_BIT] && slot_reg == 3'h4);
  c_static:     cover property (static_on && supply_on);
  c_both_force: cover property (all_on && blank && supply_on);
  c_slot_wrap:  cover property (osc_tick && tick_cnt_reg == slot_ticks - 9'h001 && slot_reg == 3'h3);

endmodule

// ==== verilog/lsd_pkg.sv ====
package lsd_pkg;

  // ==========================================================================
  // Bus and register map
  // ==========================================================================
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned IDX_W         = 18;
  // Word index of each location; byte address is four times the index
  localparam logic [17:0] DMEM_FIRST_IDX = 18'h0F000;
  localparam logic [17:0] DMEM_LAST_IDX  = 18'h0F09F;
  localparam logic [17:0] CTRL_IDX       = 18'h0F0C0;
  localparam logic [17:0] STAT_IDX       = 18'h0F0C1;
  localparam int unsigned DMEM_WORDS     = 160;

  // Control register fields
  localparam int unsigned CTRL_SUPPLY_BIT = 0;
  localparam int unsigned CTRL_ALLON_BIT  = 1;
  localparam int unsigned CTRL_BLANK_BIT  = 2;
  localparam int unsigned CTRL_DUTYL_BIT  = 3;
  localparam int unsigned CTRL_DUTYH_BIT  = 4;
  localparam int unsigned CTRL_STATIC_BIT = 5;
  localparam logic [5:0]  CTRL_RESET      = 6'h00;

  // ==========================================================================
  // Panel geometry and timing
  // ==========================================================================
  localparam int unsigned NUM_BP     = 8;
  localparam int unsigned NUM_FP     = 56;
  localparam int unsigned OSC_HZ     = 32768;
  localparam int unsigned FRAME_HZ_8 = 32;
  localparam int unsigned FRAME_HZ_5 = 25;
  localparam int unsigned FRAME_HZ_4 = 32;
  // Oscillator ticks per backplane slot, rounded down
  localparam logic [8:0]  SLOT_TICKS_8 = 9'(OSC_HZ / (FRAME_HZ_8 * 8));
  localparam logic [8:0]  SLOT_TICKS_5 = 9'(OSC_HZ / (FRAME_HZ_5 * 5));
  localparam logic [8:0]  SLOT_TICKS_4 = 9'(OSC_HZ / (FRAME_HZ_4 * 4));

  // Drive level codes: ground, then the three bias levels
  typedef enum logic [1:0] {
    LVL_V0  = 2'b00,
    LVL_VC1 = 2'b01,
    LVL_VC2 = 2'b10,
    LVL_VC3 = 2'b11
  } lsd_level_t;

  typedef struct packed {
    logic [NUM_BP-1:0][1:0] backplane_lines;
    logic [NUM_FP-1:0][1:0] frontplane_lines;
  } lsd_drive_t;

endpackage

// ==== tb/lsd_panel.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Passive glass model
// ==========================================================================
module lsd_panel
  import lsd_pkg::*;
(
  input  wire lsd_drive_t                 drive_i,
  output logic [NUM_BP-1:0][NUM_FP-1:0]   lit_o
);
  // A cell lights only at full bias (ground against top level), either sign
  always_comb
  begin
    for (int c = 0; c < NUM_BP; c++)
    begin
      for (int s = 0; s < NUM_FP; s++)
      begin
        lit_o[c][s] = ({drive_i.frontplane_lines[s], drive_i.backplane_lines[c]} == 4'h3) ||
                      ({drive_i.frontplane_lines[s], drive_i.backplane_lines[c]} == 4'hC);
      end
    end
  end
endmodule

// ==== tb/lsd_top_test.sv ====
`timescale 1ns/1ps
module lsd_top_test;
  import lsd_pkg::*;
  logic                         clk_i;
  logic                         nrst_i;
  logic                         psel_i;
  logic                         penable_i;
  logic                         pwrite_i;
  logic [ADDR_W-1:0]            paddr_i;
  logic [31:0]                  pwdata_i;
  logic [31:0]                  prdata_o;
  logic                         pready_o;
  logic                         pslverr_o;
  logic                         slow_oscillator_clock_i;
  logic                         bias_enable_o;
  lsd_drive_t                   drive_o;
  logic [NUM_BP-1:0][NUM_FP-1:0] lit;
  lsd_drive_t                   drive_s;
  logic [NUM_BP-1:0][NUM_FP-1:0] lit_s;
  logic [31:0]                  r_data;
  logic                         r_err;
  int                           n_errors = 0;
  int                           n_checks = 0;
  int                           cyc = 0;

  // ========================================================================
  // Design, panel, clocks
  // ========================================================================
  // First frontplane pair is DC so the plain-output path is exercised
  lsd_top #(.DC_PAIR_MASK(28'h0000001), .HALF_BIAS_OPT(1'b0)) lsd_top_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .slow_oscillator_clock_i(slow_oscillator_clock_i), .bias_enable_o(bias_enable_o), .drive_o(drive_o));
  lsd_panel lsd_panel_i (.drive_i(drive_o), .lit_o(lit));
  // Half-bias build on the same bus, so static drive can be reached
  lsd_top #(.DC_PAIR_MASK(28'h0000000), .HALF_BIAS_OPT(1'b1)) lsd_top_s_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(), .pready_o(), .pslverr_o(),
    .slow_oscillator_clock_i(slow_oscillator_clock_i), .bias_enable_o(), .drive_o(drive_s));
  lsd_panel lsd_panel_s_i (.drive_i(drive_s), .lit_o(lit_s));

  // System clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Fast oscillator: six system clocks per period keeps frames short
  initial
  begin
    forever
    begin
      repeat (3) @(posedge clk_i);
      slow_oscillator_clock_i <= ~slow_oscillator_clock_i;
    end
  end
  // Cycle count for frame timing
  always @(posedge clk_i) cyc <= cyc + 1;

  // ========================================================================
  // Helpers
  // ========================================================================
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; waits for pready with a bounded count
  task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    // A transfer that never answers is a mismatch, not a silent return
    if (pready_o !== 1'b1)
    begin
      n_errors++;
      $display("Error at %0t: bus transfer got no answer", $time);
    end
    r_data = prdata_o;
    r_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic logic [3:0] pat(input int w);
    return 4'(w * 7 + 3);
  endfunction
  function automatic logic seg(input int s, input int c);
    logic [3:0] p;
    p = pat((s * 8 + c) / 4);
    return p[(s * 8 + c) % 4];
  endfunction
  // Wait until backplane c is (or is not) at a level
  task automatic wait_bp(input int c, input lsd_level_t lv, input logic eq);
    int n;
    n = 0;
    while (((drive_o.backplane_lines[c] === lv) != eq) && n < 20000)
    begin
      @(posedge clk_i);
      n++;
    end
    check(64'(n < 20000), 64'h1, "backplane select timeout");
  endtask
  // Mode 0 follows memory, 1 all lit, 2 all dark; DC pair left out
  task automatic show(input int c, input int mode);
    logic [NUM_FP-1:0] exp;
    repeat (3) @(posedge clk_i);
    wait_bp(c, LVL_VC3, 1'b1);
    for (int s = 0; s < NUM_FP; s++)
      exp[s] = (mode == 1) ? 1'b1 : (mode == 2) ? 1'b0 : seg(s, c);
    check(64'(lit[c][55:2]), 64'(exp[55:2]), "segment row");
  endtask

  // ========================================================================
  // Scenarios
  // ========================================================================
  task automatic t_regs;
    check(64'(drive_o.backplane_lines), 64'h0, "backplanes at reset");
    apb(1'b0, CTRL_IDX, 32'h0);
    check(64'(r_data), 64'(CTRL_RESET), "control reset");
    apb(1'b0, 18'h0F0A0, 32'h0);
    check({r_err, r_data}, 64'h100000000, "unmapped read");
    for (int w = 0; w < DMEM_WORDS; w++)
      apb(1'b1, DMEM_FIRST_IDX + 18'(w), 32'(pat(w)));
    for (int w = 0; w < DMEM_WORDS; w++)
    begin
      apb(1'b0, DMEM_FIRST_IDX + 18'(w), 32'h0);
      check(64'(r_data), 64'(pat(w)), "memory readback");
    end
    apb(1'b1, CTRL_IDX, 32'h20);
    apb(1'b0, CTRL_IDX, 32'h0);
    check(64'(r_data[5]), 64'h0, "static without option");
    repeat (3) @(posedge clk_i);
    check(64'(drive_o.frontplane_lines[1]), seg(1, 0) ? 64'h3 : 64'h0, "dc pin supply off");
  endtask
  task automatic t_display;
    apb(1'b1, CTRL_IDX, 32'h1);
    repeat (2) @(posedge clk_i);
    check(64'(bias_enable_o), 64'h1, "bias on");
    check(64'(drive_o.frontplane_lines[0]), seg(0, 0) ? 64'h3 : 64'h0, "dc pin supply on");
    for (int c = 0; c < 4; c++)
      show(c, 0);
    apb(1'b1, CTRL_IDX, 32'h3);
    show(1, 1);
    apb(1'b1, CTRL_IDX, 32'h5);
    show(2, 2);
    apb(1'b1, CTRL_IDX, 32'h7);
    show(3, 1);
    apb(1'b1, CTRL_IDX, 32'h1);
    show(0, 0);
  endtask
  task automatic frame(input logic [1:0] duty, input int nbp, input int ticks);
    int t0;
    int d;
    apb(1'b1, CTRL_IDX, 32'({duty, 3'b001}));
    show(nbp - 1, 0);
    check(64'(drive_o.backplane_lines) >> (2 * nbp), 64'h0, "unused backplanes");
    wait_bp(0, LVL_VC3, 1'b1);
    t0 = cyc;
    // Slot zero lasts hundreds of cycles, so the status read lands inside it
    apb(1'b0, STAT_IDX, 32'h0);
    check(64'(r_data[3:0]), 64'h0, "status slot zero");
    wait_bp(0, LVL_VC3, 1'b0);
    wait_bp(0, LVL_VC3, 1'b1);
    d = cyc - t0 - nbp * ticks * 6;
    check((d <= 6 && d >= -6) ? 64'h0 : 64'(d), 64'h0, "frame length");
  endtask
  // Static drive on the half-bias build; frontplane 10 gets all-zero bits
  task automatic t_static;
    logic [NUM_FP-1:0] exp;
    exp = '0;
    apb(1'b1, DMEM_FIRST_IDX + 18'h00014, 32'h0);
    apb(1'b1, DMEM_FIRST_IDX + 18'h00015, 32'h0);
    apb(1'b1, CTRL_IDX, 32'h21);
    repeat (3) @(posedge clk_i);
    for (int s = 0; s < NUM_FP; s++)
      for (int c = 0; c < NUM_BP; c++)
        exp[s] = exp[s] | seg(s, c);
    exp[10] = 1'b0;
    check(64'(lit_s[0]), 64'(exp), "static row zero");
    check(64'(lit_s[3]), 64'(exp), "static row three");
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (95000) @(posedge clk_i);
    n_errors++;
    results();
  end
  // Main sequence
  initial
  begin
    {nrst_i, psel_i, penable_i, pwrite_i, slow_oscillator_clock_i} = 5'h00;
    paddr_i = '0;
    pwdata_i = 32'h0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_display();
    frame(2'b00, 4, 256);
    frame(2'b01, 5, 262);
    frame(2'b11, 8, 128);
    t_static();
    apb(1'b1, CTRL_IDX, 32'h0);
    repeat (3) @(posedge clk_i);
    check({bias_enable_o, 16'(drive_o.backplane_lines)}, 64'h0, "supply off");
    results();
  end
endmodule
